// file: dv/mrc_master_model.sv
// master-side model: sends request packets, collects response bytes
module mrc_master_model (
    // clock
    input wire logic sys_clk,
    // request byte stream into the handler
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_end,
    // response byte stream out of the handler
    input wire logic tx_valid_q,
    input wire logic [7:0] tx_data_q,
    output logic tx_ready,
    // slow consumer mode
    input wire logic stall
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rsp[$];
    logic [3:0] tick_q = 4'h0;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_end = 1'b0;
        tx_ready = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] a;
        a = 16'hffff;
        foreach (b[i]) begin
            a[7:0] = a[7:0] ^ b[i];
            for (int j = 0; j < 8; j++) begin
                a = a[0] ? ((a >> 1) ^ 16'ha001) : (a >> 1);
            end
        end
        return a;
    endfunction

    // bad flips one crc bit so the receiver sees a nonzero remainder
    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = crc16(b) ^ {15'h0000, bad};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            @(posedge sys_clk);
            rx_valid <= 1'b1; // bytes back to back, no idle gap
            rx_data <= b[i];
        end
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_data <= ~b[b.size() - 1];
        rx_end <= 1'b1;
        @(posedge sys_clk);
        rx_end <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one cycle in four when stalling, to push the skid buffer
    always @(posedge sys_clk) begin
        tick_q <= tick_q + 4'h1;
        tx_ready <= stall ? (tick_q[1] & tick_q[0]) : 1'b1;
        if (tx_valid_q && tx_ready) begin
            rsp.push_back(tx_data_q);
        end
    end
endmodule

// file: dv/test_modbus_rtu_crc_read_handler.sv
// self-checking testbench of the request handler
module test_modbus_rtu_crc_read_handler;
    timeunit 1ns;
    timeprecision 1ps;

    typedef logic [7:0] mrc_bytes_t[$];
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic stall = 1'b0;
    logic any_addr = 1'b0;
    logic rd_ack = 1'b0;
    logic [15:0] rd_data = 16'h0000;
    logic rx_valid, rx_end, rd_req_q, op_req_q, tx_valid_q, tx_ready;
    logic [7:0] rx_data, op_func_q, tx_data_q;
    mrc_pkg::mrc_rd_req_t rd_info_q;
    logic [7:0] op_last = 8'h00;
    logic setting_seen = 1'b0;
    int num_errors = 0;
    int checked = 0;
    int op_cnt = 0;
    mrc_bytes_t none;

    always #25 sys_clk = ~sys_clk;

    mrc_handler DUT (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
        .slave_addr(8'h11), .any_addr(any_addr),
        .rd_req_q(rd_req_q), .rd_info_q(rd_info_q),
        .rd_ack(rd_ack), .rd_data(rd_data),
        .op_req_q(op_req_q), .op_func_q(op_func_q),
        .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q), .tx_ready(tx_ready)
    );

    mrc_master_model u_master (
        .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_end(rx_end), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
        .tx_ready(tx_ready), .stall(stall)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] mem(input logic [15:0] a);
        case (a)
            16'h4050: return 16'h0028;
            16'h4051: return 16'h012c;
            16'h4052: return 16'h0000;
            default: return a ^ 16'h5a5a;
        endcase
    endfunction

    // register store answers one cycle after each request
    always @(posedge sys_clk) begin
        rd_ack <= rd_req_q;
        rd_data <= rd_req_q ? mem(rd_info_q.addr) : ~rd_data;
        if (rd_req_q) begin
            setting_seen <= rd_info_q.setting;
        end
        if (op_req_q) begin
            op_cnt <= op_cnt + 1;
            op_last <= op_func_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_num(input string n, input int e, input int g);
        checked++;
        if (g != e) begin
            num_errors++;
            $display("FAIL %s expected %0d seen %0d", n, e, g);
        end
    endtask

    function automatic mrc_bytes_t with_crc(input mrc_bytes_t b);
        logic [15:0] c;
        c = u_master.crc16(b);
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        return b;
    endfunction

    function automatic mrc_bytes_t rd_rsp(input logic [7:0] fc,
                                          input logic [15:0] a, input int n);
        mrc_bytes_t b;
        logic [15:0] w;
        b = '{8'h11, fc, 8'(2 * n)};
        for (int k = 0; k < n; k++) begin
            w = mem(a + 16'(k));
            b.push_back(w[15:8]);
            b.push_back(w[7:0]);
        end
        return with_crc(b);
    endfunction

    // bounded wait, then a quiet spell so stray extra bytes are caught
    task automatic run(input mrc_bytes_t req, input logic bad,
                       input mrc_bytes_t exp);
        u_master.rsp.delete();
        u_master.send(req, bad);
        for (int i = 0; i < 3000 && u_master.rsp.size() < exp.size(); i++)
            @(posedge sys_clk);
        repeat (20) @(posedge sys_clk);
        cmp_num("response length", exp.size(),
                u_master.rsp.size());
        foreach (exp[i]) begin
            if (i < u_master.rsp.size())
                cmp_byte("response byte", exp[i],
                         u_master.rsp[i]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_example();
        stall <= 1'b1;
        run('{8'h11, 8'h04, 8'h40, 8'h50, 8'h00, 8'h03}, 1'b0,
            '{8'h11, 8'h04, 8'h06, 8'h00, 8'h28, 8'h01, 8'h2c, 8'h00,
              8'h00, 8'h0d, 8'h60});
        cmp_byte("setting flag", 8'h01, {7'h00, setting_seen});
        stall <= 1'b0;
    endtask

    task automatic t_counts();
        run('{8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h7d}, 1'b0,
            rd_rsp(8'h03, 16'h0010, 125));
        cmp_byte("setting flag", 8'h00, {7'h00, setting_seen});
        run('{8'h11, 8'h04, 8'h00, 8'h10, 8'h00, 8'h7e}, 1'b0,
            with_crc('{8'h11, 8'h84, 8'h03}));
        run('{8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h00}, 1'b0,
            with_crc('{8'h11, 8'h83, 8'h03}));
    endtask

    task automatic t_ignored();
        run('{8'h11, 8'h04, 8'h40, 8'h50, 8'h00, 8'h03}, 1'b1,
            none);
        run('{8'h11, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, 1'b1,
            none);
        run('{8'h12, 8'h04, 8'h40, 8'h50, 8'h00, 8'h03}, 1'b0,
            none);
        run('{8'h00, 8'h06, 8'h40, 8'h51, 8'h00, 8'hc8}, 1'b0,
            none);
        cmp_num("op count", 0, op_cnt);
        run('{8'h00, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, 1'b0,
            none);
        cmp_num("op count", 1, op_cnt);
        cmp_byte("op function", 8'h05, op_last);
    endtask

    task automatic t_funcs();
        run('{8'h11, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, 1'b0,
            none);
        cmp_byte("op function", 8'h05, op_last);
        run('{8'h11, 8'h06, 8'h40, 8'h51, 8'h00, 8'hc8}, 1'b0,
            none);
        cmp_byte("op function", 8'h06, op_last);
        run('{8'h11, 8'h10, 8'h40, 8'h51, 8'h00, 8'h02, 8'h04, 8'h00,
              8'hc8, 8'h00, 8'h01}, 1'b0, none);
        cmp_byte("op function", 8'h10, op_last);
        cmp_num("op count", 4, op_cnt);
        run('{8'h11, 8'h39}, 1'b0,
            '{8'h11, 8'hb9, 8'h01, 8'h93, 8'h95});
        run('{8'h11, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0,
            with_crc('{8'h11, 8'h82, 8'h01}));
    endtask

    // front-port mode: any non-zero address answered, zero still ignored
    task automatic t_any_addr();
        any_addr <= 1'b1;
        run('{8'h12, 8'h03, 8'h40, 8'h52, 8'h00, 8'h01}, 1'b0,
            with_crc('{8'h12, 8'h03, 8'h02, 8'h00, 8'h00}));
        cmp_byte("setting flag", 8'h01, {7'h00, setting_seen});
        run('{8'h00, 8'h04, 8'h40, 8'h50, 8'h00, 8'h01}, 1'b0,
            none);
        cmp_num("op count", 4, op_cnt);
        any_addr <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_example();
        t_counts();
        t_ignored();
        t_funcs();
        t_any_addr();
        results();
    end

    // whole run is under two thousand cycles; this leaves a wide margin
    initial begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        $display("FAIL watchdog expected end seen hang");
        results();
    end
endmodule

// file: include/mrc_pkg.sv
// shared constants and types of the request handler
package mrc_pkg;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_PRESET = 16'hffff;
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_INPUT = 8'h04;
    localparam logic [7:0] FC_EXEC = 8'h05;
    localparam logic [7:0] FC_STORE_ONE = 8'h06;
    localparam logic [7:0] FC_STORE_MANY = 8'h10;
    localparam logic [7:0] EXC_FLAG = 8'h80;
    localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [6:0] MAX_REGS = 7'h7d;
    localparam logic [3:0] READ_REQ_LEN = 4'h8;
    localparam logic [3:0] MIN_PKT_LEN = 4'h4;
    localparam logic [3:0] HDR_BYTES = 4'h6;
    localparam logic [15:0] SETTING_BASE = 16'h4000;

    typedef struct packed {
        logic [15:0] addr;
        logic setting;
    } mrc_rd_req_t;

    typedef enum {
        S_IDLE, S_ADDR, S_FUNC, S_BCNT, S_FETCH, S_WAIT,
        S_DHI, S_DLO, S_ERR, S_CRCL, S_CRCH
    } mrc_state_t;
endpackage

// file: logic/mrc_crc.sv
// byte-wide reflected crc-16 accumulator
module mrc_crc (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // byte stream
    input wire logic init,
    input wire logic en,
    input wire logic [7:0] din,
    // running remainder
    output logic [15:0] crc_q
);
    function automatic logic [15:0] crc_byte(input logic [15:0] a,
                                             input logic [7:0] d);
        logic [15:0] w;
        w = a ^ {8'h00, d};
        for (int j = 0; j < 8; j++) begin
            // shift first, then fold in the polynomial on a carry
            w = w[0] ? ((w >> 1) ^ mrc_pkg::CRC_POLY) : (w >> 1);
        end
        return w;
    endfunction

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            crc_q <= mrc_pkg::CRC_PRESET;
        end else if (en) begin
            // init with en folds the first byte onto a fresh preset
            crc_q <= crc_byte(init ? mrc_pkg::CRC_PRESET : crc_q, din);
        end else if (init) begin
            crc_q <= mrc_pkg::CRC_PRESET;
        end
    end
endmodule

// file: logic/mrc_handler.sv
// slave request checker and register-read responder
//
// Contract
// - checksum covers payload data bytes only, framing bits excluded.
// - reflected crc-16 polynomial a001 hex drives the shift feedback.
// - sixteen-bit accumulator preset to ffff before the first byte.
// - xor byte into low half, eight right shifts, fold poly on carry.
// - final accumulator is the checksum, appended after last payload byte.
// - packet good only when checksum over all bytes leaves zero.
// - only function codes 03, 04, 05, 06 and 10 hex accepted.
// - codes 03 and 04 behave identically as register reads.
// - each sixteen-bit register value sent high byte first.
// - register count one to 125 per read request.
// - response: address, function echo, byte count, data ascending, crc.
// - data kind chosen from start address only, not function code; code flags each register by its own address.
// - bad checksum: packet neither acted on nor answered.
// - foreign address ignored; address zero broadcast only for 05; code answers any non-zero address when any_addr is set.
// - rejection echoes function with top bit set, error code, crc.
// - packet ends after 3.5 idle characters; no such gap inside.
module mrc_handler #(
    parameter logic [15:0] SETTING_BASE = mrc_pkg::SETTING_BASE
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // received payload bytes and end-of-packet pulse
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    // configuration
    input wire logic [7:0] slave_addr,
    input wire logic any_addr,
    // register read port
    output logic rd_req_q,
    output mrc_pkg::mrc_rd_req_t rd_info_q,
    input wire logic rd_ack,
    input wire logic [15:0] rd_data,
    // accepted write and execute requests
    output logic op_req_q,
    output logic [7:0] op_func_q,
    // response byte stream
    output logic tx_valid_q,
    output logic [7:0] tx_data_q,
    input wire logic tx_ready
);
    // a zero base would flag every address as a setting
    if (SETTING_BASE == 16'h0000) begin : g_bad_base
        $error("setting base of zero leaves no actual values");
    end

    ////////////////////////////////////////////////////////////////////////
    mrc_pkg::mrc_state_t state_q;
    logic [3:0] len_q;
    logic [7:0] hdr_q [6];
    logic [15:0] rx_crc, tx_crc, raddr_q, data_q, start, count;
    logic [6:0] cnt_q, left_q;
    logic [7:0] fc_q, exc_q, echo_q, push_byte;
    logic ex_q, push, in_ready_q, skid_v_q, take;
    logic [7:0] skid_q;
    logic frame_ok, addr_hit, bcast, is_read, supported, end_idle;

    // half-duplex: bytes arriving while answering are dropped
    assign take = rx_valid && state_q == mrc_pkg::S_IDLE;
    assign end_idle = rx_end && state_q == mrc_pkg::S_IDLE;

    mrc_crc u_rx_crc (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .init(len_q == 4'h0),
        .en(take),
        .din(rx_data),
        .crc_q(rx_crc)
    );

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            len_q <= 4'h0;
        end else if (end_idle) begin
            len_q <= 4'h0;
        end else if (take && len_q != 4'hf) begin
            len_q <= len_q + 4'h1;
        end
    end

    for (genvar g = 0; g < 6; g++) begin : g_hdr
        always_ff @(posedge sys_clk or negedge reset_n) begin
            if (!reset_n) begin
                hdr_q[g] <= 8'h00;
            end else if (take && len_q == 4'(g)) begin
                hdr_q[g] <= rx_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign frame_ok = rx_crc == 16'h0000 && len_q >= mrc_pkg::MIN_PKT_LEN;
    assign bcast = hdr_q[0] == mrc_pkg::ADDR_BCAST;
    assign addr_hit = !bcast && (any_addr || hdr_q[0] == slave_addr);
    assign is_read = hdr_q[1] == mrc_pkg::FC_RD_HOLD
        || hdr_q[1] == mrc_pkg::FC_RD_INPUT;
    assign supported = is_read || hdr_q[1] == mrc_pkg::FC_EXEC
        || hdr_q[1] == mrc_pkg::FC_STORE_ONE
        || hdr_q[1] == mrc_pkg::FC_STORE_MANY;
    assign start = {hdr_q[2], hdr_q[3]};
    assign count = {hdr_q[4], hdr_q[5]};

    always_comb begin
        push_byte = 8'h00;
        case (state_q)
            mrc_pkg::S_ADDR: push_byte = echo_q;
            mrc_pkg::S_FUNC: push_byte = ex_q ? (fc_q | mrc_pkg::EXC_FLAG) : fc_q;
            mrc_pkg::S_BCNT: push_byte = {cnt_q, 1'b0};
            mrc_pkg::S_DHI: push_byte = data_q[15:8];
            mrc_pkg::S_DLO: push_byte = data_q[7:0];
            mrc_pkg::S_ERR: push_byte = exc_q;
            mrc_pkg::S_CRCL: push_byte = tx_crc[7:0];
            mrc_pkg::S_CRCH: push_byte = tx_crc[15:8];
            default: push_byte = 8'h00;
        endcase
    end

    always_comb begin
        case (state_q)
            mrc_pkg::S_IDLE, mrc_pkg::S_FETCH, mrc_pkg::S_WAIT: push = 1'b0;
            default: push = in_ready_q;
        endcase
    end

    mrc_crc u_tx_crc (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .init(state_q == mrc_pkg::S_ADDR),
        .en(push && state_q != mrc_pkg::S_CRCL
            && state_q != mrc_pkg::S_CRCH),
        .din(push_byte),
        .crc_q(tx_crc)
    );

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= mrc_pkg::S_IDLE;
            fc_q <= 8'h00;
            echo_q <= 8'h00;
            exc_q <= 8'h00;
            ex_q <= 1'b0;
            cnt_q <= 7'h00;
            left_q <= 7'h00;
            raddr_q <= 16'h0000;
            data_q <= 16'h0000;
        end else begin
            case (state_q)
                mrc_pkg::S_IDLE: begin
                    fc_q <= hdr_q[1];
                    echo_q <= hdr_q[0];
                    if (end_idle && frame_ok && addr_hit) begin
                        if (!supported) begin
                            ex_q <= 1'b1;
                            exc_q <= mrc_pkg::EXC_BAD_FUNC;
                            state_q <= mrc_pkg::S_ADDR;
                        end else if (is_read) begin
                            ex_q <= 1'b0;
                            if (len_q != mrc_pkg::READ_REQ_LEN
                                || count == 16'h0000
                                || count > 16'(mrc_pkg::MAX_REGS)) begin
                                ex_q <= 1'b1;
                                exc_q <= mrc_pkg::EXC_BAD_VALUE;
                            end
                            cnt_q <= count[6:0];
                            left_q <= count[6:0];
                            raddr_q <= start;
                            state_q <= mrc_pkg::S_ADDR;
                        end
                    end
                end
                mrc_pkg::S_ADDR: if (push) begin
                    state_q <= mrc_pkg::S_FUNC;
                end
                mrc_pkg::S_FUNC: if (push) begin
                    state_q <= ex_q ? mrc_pkg::S_ERR : mrc_pkg::S_BCNT;
                end
                mrc_pkg::S_BCNT: if (push) begin
                    state_q <= mrc_pkg::S_FETCH;
                end
                mrc_pkg::S_FETCH: state_q <= mrc_pkg::S_WAIT;
                mrc_pkg::S_WAIT: if (rd_ack) begin
                    data_q <= rd_data;
                    state_q <= mrc_pkg::S_DHI;
                end
                mrc_pkg::S_DHI: if (push) begin
                    state_q <= mrc_pkg::S_DLO;
                end
                mrc_pkg::S_DLO: if (push) begin
                    left_q <= left_q - 7'h01;
                    raddr_q <= raddr_q + 16'h0001;
                    state_q <= left_q == 7'h01 ? mrc_pkg::S_CRCL
                                               : mrc_pkg::S_FETCH;
                end
                mrc_pkg::S_ERR: if (push) begin
                    state_q <= mrc_pkg::S_CRCL;
                end
                mrc_pkg::S_CRCL: if (push) begin
                    state_q <= mrc_pkg::S_CRCH;
                end
                mrc_pkg::S_CRCH: if (push) begin
                    state_q <= mrc_pkg::S_IDLE;
                end
                default: state_q <= mrc_pkg::S_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_req_q <= 1'b0;
            rd_info_q <= '0;
        end else begin
            rd_req_q <= state_q == mrc_pkg::S_FETCH;
            if (state_q == mrc_pkg::S_FETCH) begin
                rd_info_q.addr <= raddr_q;
                // kind follows the address; 03 and 04 are not told apart
                rd_info_q.setting <= raddr_q >= SETTING_BASE;
            end
        end
    end

    // writes and operations are executed elsewhere and answered there
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            op_req_q <= 1'b0;
            op_func_q <= 8'h00;
        end else begin
            op_req_q <= end_idle && frame_ok && supported && !is_read
                && (addr_hit || (bcast && hdr_q[1] == mrc_pkg::FC_EXEC));
            if (end_idle) begin
                op_func_q <= hdr_q[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry skid: output register plus one spare, ready is registered
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            skid_v_q <= 1'b0;
            skid_q <= 8'h00;
            in_ready_q <= 1'b1;
        end else begin
            if (!tx_valid_q || tx_ready) begin
                if (skid_v_q) begin
                    tx_data_q <= skid_q;
                    skid_v_q <= 1'b0;
                    in_ready_q <= 1'b1;
                end else begin
                    tx_valid_q <= push;
                    tx_data_q <= push_byte;
                end
            end else if (push) begin
                skid_q <= push_byte;
                skid_v_q <= 1'b1;
                in_ready_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    a_addr_echo: assert property (state_q == mrc_pkg::S_ADDR && push |-> push_byte == hdr_q[0]) else $error("address not echoed");
    a_exc_func: assert property (state_q == mrc_pkg::S_FUNC && push && ex_q |-> push_byte == (hdr_q[1] | mrc_pkg::EXC_FLAG)) else $error("exception flag missing");
    a_byte_count: assert property (state_q == mrc_pkg::S_BCNT && push |-> push_byte == 8'(2 * count)) else $error("byte count wrong");
    a_count_range: assert property (state_q == mrc_pkg::S_BCNT |-> cnt_q >= 7'h01 && cnt_q <= 7'h7d) else $error("count out of range");
    a_bad_crc_quiet: assert property (end_idle && rx_crc != 16'h0000 |=> state_q == mrc_pkg::S_IDLE && !op_req_q) else $error("bad packet acted on");
    a_unsup_exc: assert property (end_idle && frame_ok && addr_hit && !supported |=> state_q == mrc_pkg::S_ADDR && ex_q && exc_q == 8'h01) else $error("unsupported code not rejected");
    a_crc_order: assert property (state_q == mrc_pkg::S_CRCL && push |-> push_byte == tx_crc[7:0] ##1 state_q == mrc_pkg::S_CRCH) else $error("checksum order wrong");
    a_data_hi_first: assert property (state_q == mrc_pkg::S_WAIT && rd_ack |=> state_q == mrc_pkg::S_DHI && data_q[15:8] == $past(rd_data[15:8])) else $error("high byte not first");
    a_fetch_req: assert property (state_q == mrc_pkg::S_FETCH |=> rd_req_q && rd_info_q.addr == $past(raddr_q)) else $error("read request lost");
    a_buf_hold: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q)) else $error("stalled byte changed");

    c_read_done: cover property (state_q == mrc_pkg::S_CRCH && push && !ex_q);
    c_exception: cover property (state_q == mrc_pkg::S_ERR && push);
    c_broadcast: cover property (op_req_q && echo_q == 8'h00);
    c_stall: cover property (skid_v_q && !tx_ready);
endmodule
